/* File: shared/fsr_pkg.sv */
// Constants, register map and carrier types of the flow spike filter
package fsr_pkg;

  localparam int DATA_W        = 16;
  localparam int SUM_W         = 23;
  localparam int WIN_DEPTH     = 128;
  localparam int IN_FIFO_DEPTH = 16;

  // Sample slot timing: ten slots per second
  localparam int SAMPLE_PERIOD_NS = 100_000_000;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SAMPLES = 8'h04;
  localparam logic [7:0] REG_PERCENT = 8'h08;
  localparam logic [7:0] REG_TLIMIT  = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_AVG     = 8'h14;

  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int ST_PEND_BIT  = 0;
  localparam int ST_DIR_BIT   = 1;
  localparam int ST_CNT_LSB   = 8;

  // Ranges and reset values; time limit counts tenths of a second
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam logic [6:0] SAMPLES_MIN = 7'h01;
  localparam logic [6:0] SAMPLES_MAX = 7'h7d;
  localparam logic [6:0] SAMPLES_RST = 7'h5a;
  localparam logic [6:0] PERCENT_MAX = 7'h64;
  localparam logic [6:0] PERCENT_RST = 7'h02;
  localparam int         PCT_SCALE   = 100;
  localparam logic [11:0] TLIMIT_MIN = 12'h006;
  localparam logic [11:0] TLIMIT_MAX = 12'ha00;
  localparam logic [11:0] TLIMIT_RST = 12'h014;

  typedef struct packed {
    logic        enable;
    logic [6:0]  samples;
    logic [6:0]  percent;
    logic [11:0] tlimit;
  } fsr_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fsr_bus_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_INS  = 2'b10,
    ST_OUT  = 2'b11
  } fsr_state_t;

endpackage

/* File: hdl/fsr_fifo.sv */
// Synchronous FIFO with registered read data, also used as sample window
`timescale 1ns/10ps
module fsr_fifo
  import fsr_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = IN_FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             pushValid,
  output logic                  pushReady,
  input  wire logic [WIDTH-1:0] pushData,
  output logic                  popValid,
  input  wire logic             popReady,
  output logic [WIDTH-1:0]      popData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             pushReady_q;
  logic             popValid_q;
  logic [WIDTH-1:0] popData_q;
  logic             push;
  logic             pop;

  assign push      = pushValid && pushReady_q && !flush;
  assign pop       = popValid_q && popReady && !flush;
  assign pushReady = pushReady_q;
  assign popValid  = popValid_q;
  assign popData   = popData_q;

  always_comb
  begin
    cnt_d = cnt_q;
    if (flush)
      cnt_d = '0;
    else if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      if (flush)
      begin
        wrPtr_q <= '0;
        rdPtr_q <= '0;
      end
      else
      begin
        if (push)
          wrPtr_q <= wrPtr_q + 1'b1;
        if (pop)
          rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= pushData;
  end

  // Head word is re-read every cycle; valid drops for one cycle after a pop
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pushReady_q <= 1'b1;
      popValid_q  <= 1'b0;
      popData_q   <= '0;
    end
    else
    begin
      pushReady_q <= (cnt_d != (AW+1)'(DEPTH));
      popValid_q  <= !flush && (cnt_q != '0) && !pop;
      popData_q   <= mem[rdPtr_q];
    end
  end
endmodule

/* File: hdl/fsr_filter.sv */
// Flow spike rejection filter: band check, spike hold, running average
`timescale 1ns/10ps
// How it works
// [R1] Upper bound is average plus average times percent over 100.
// [R2] Lower bound is average minus average times percent over 100.
// [R3] In-band sample joins the average; new average is output.
// [R4] First out-of-band sample is held; average output unchanged.
// [R5] Held sample is dropped when the next sample is in band.
// [R6] Same-direction follow-up adds the held sample to the average.
// [R7] One sample is processed every tenth of a second.
// [R8] Output is the running average over the sample-count window.
// [R9] Time limit lets output jump to a sustained new level.
// [R10] Sample count is 1 to 125, default 90, tenths each.
// [R11] Percent tolerance is 0 to 100, default 2.
// [R12] On time limit, average is cleared and restarted at new value.
// [R13] Enable switch turns qualification and averaging on or off.
// [R14] Opposite-direction follow-up replaces the held sample.
// [R15] Timer starts on first outlier, clears on accepted in-band sample.
module fsr_filter
  import fsr_pkg::*;
#(
  parameter int TICK_CYCLES = SAMPLE_CYCLES,
  parameter int IN_DEPTH    = IN_FIFO_DEPTH
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire fsr_bus_t          bus,
  output logic [31:0]            rdData,
  input  wire logic              sampleValid,
  output logic                   sampleReady,
  input  wire logic [DATA_W-1:0] sampleData,
  output logic                   flowValid,
  output logic [DATA_W-1:0]      flowData
);
  fsr_cfg_t          cfg_q;
  fsr_state_t        state_q;
  logic [31:0]       rdData_q;
  logic [31:0]       tickCnt_q;
  logic              tickPend_q;
  logic [DATA_W-1:0] sample_q;
  logic [DATA_W-1:0] avg_q;
  logic [SUM_W-1:0]  sum_q;
  logic [7:0]        winCnt_q;
  logic              pend_q;
  logic              dir_q;
  logic [DATA_W-1:0] pendVal_q;
  logic [11:0]       run_q;
  logic [DATA_W-1:0] insVal_q;
  logic              flowValid_q;
  logic [DATA_W-1:0] flowData_q;

  logic              inValid;
  logic              inTake;
  logic [DATA_W-1:0] inData;
  logic              winFlush;
  logic              winPush;
  logic              winPushReady;
  logic              winPop;
  logic              winValid;
  logic [DATA_W-1:0] winData;
  logic              tickHit;
  logic              trim;
  logic              needPop;
  logic              insGo;
  logic [SUM_W-1:0]  devWide;
  logic [DATA_W-1:0] dev;
  logic [DATA_W:0]   hiBound;
  logic [DATA_W-1:0] loBound;
  logic              outHi;
  logic              outLo;
  logic [SUM_W-1:0]  quot;
  logic [11:0]       runNext;
  logic              decIns;
  logic              decFlush;
  logic [DATA_W-1:0] decInsVal;
  logic              decPend;
  logic              decDir;
  logic [DATA_W-1:0] decPendVal;
  logic [11:0]       decRun;

  assign rdData    = rdData_q;
  assign flowValid = flowValid_q;
  assign flowData  = flowData_q;

  fsr_fifo #(.WIDTH(DATA_W), .DEPTH(IN_DEPTH)) u_in_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (1'b0),
    .pushValid (sampleValid),
    .pushReady (sampleReady),
    .pushData  (sampleData),
    .popValid  (inValid),
    .popReady  (inTake),
    .popData   (inData)
  );

  fsr_fifo #(.WIDTH(DATA_W), .DEPTH(WIN_DEPTH)) u_win_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (winFlush),
    .pushValid (winPush),
    .pushReady (winPushReady),
    .pushData  (insVal_q),
    .popValid  (winValid),
    .popReady  (winPop),
    .popData   (winData)
  );

  // Register writes, clamped into the legal ranges
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q.enable  <= CTRL_EN_RST;
      cfg_q.samples <= SAMPLES_RST;
      cfg_q.percent <= PERCENT_RST;
      cfg_q.tlimit  <= TLIMIT_RST;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        REG_CTRL:    cfg_q.enable <= bus.wdata[CTRL_EN_BIT];
        REG_SAMPLES: cfg_q.samples <=
          (bus.wdata < 32'(SAMPLES_MIN)) ? SAMPLES_MIN :
          (bus.wdata > 32'(SAMPLES_MAX)) ? SAMPLES_MAX :
          bus.wdata[6:0]; // R10
        REG_PERCENT: cfg_q.percent <=
          (bus.wdata > 32'(PERCENT_MAX)) ? PERCENT_MAX :
          bus.wdata[6:0]; // R11
        REG_TLIMIT:  cfg_q.tlimit <=
          (bus.wdata < 32'(TLIMIT_MIN)) ? TLIMIT_MIN :
          (bus.wdata > 32'(TLIMIT_MAX)) ? TLIMIT_MAX :
          bus.wdata[11:0]; // R9
        default: ;
      endcase
    end
  end

  // Register reads, data in the following cycle only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdData_q <= '0;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        REG_CTRL:    rdData_q <= 32'(cfg_q.enable);
        REG_SAMPLES: rdData_q <= 32'(cfg_q.samples);
        REG_PERCENT: rdData_q <= 32'(cfg_q.percent);
        REG_TLIMIT:  rdData_q <= 32'(cfg_q.tlimit);
        REG_STATUS:  rdData_q <= (32'(winCnt_q) << ST_CNT_LSB)
                              | (32'(dir_q) << ST_DIR_BIT)
                              | (32'(pend_q) << ST_PEND_BIT);
        REG_AVG:     rdData_q <= 32'(avg_q);
        default:     rdData_q <= '0;
      endcase
    end
    else
      rdData_q <= '0;
  end

  // Sample slot timer
  assign tickHit = (tickCnt_q == 32'(TICK_CYCLES - 1));
  // Oversized window after a shrink is trimmed before the next sample
  assign inTake  = (state_q == ST_IDLE) && tickPend_q && inValid
                   && (winCnt_q <= {1'b0, cfg_q.samples});

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tickCnt_q  <= '0;
      tickPend_q <= 1'b0;
    end
    else
    begin
      tickCnt_q <= tickHit ? '0 : tickCnt_q + 1'b1; // R7
      if (tickHit)
        tickPend_q <= 1'b1;
      else if (inTake)
        tickPend_q <= 1'b0;
    end
  end

  // Tolerance band around the running average
  assign devWide = (SUM_W'(avg_q) * SUM_W'(cfg_q.percent))
                   / SUM_W'(PCT_SCALE);
  assign dev     = devWide[DATA_W-1:0];
  assign hiBound = {1'b0, avg_q} + {1'b0, dev}; // R1
  assign loBound = avg_q - dev; // R2
  assign outHi   = {1'b0, sample_q} > hiBound;
  assign outLo   = sample_q < loBound;
  assign runNext = (run_q == TLIMIT_MAX) ? run_q : run_q + 1'b1;
  assign quot    = (winCnt_q != '0) ? sum_q / SUM_W'(winCnt_q)
                                    : SUM_W'(avg_q);

  always_comb
  begin
    decIns     = 1'b0;
    decFlush   = 1'b0;
    decInsVal  = sample_q;
    decPend    = 1'b0;
    decDir     = dir_q;
    decPendVal = pendVal_q;
    decRun     = '0;
    if (!cfg_q.enable)
      decFlush = 1'b1; // R13
    else if (winCnt_q == '0 || !(outHi || outLo))
      decIns = 1'b1; // R3 R5 R15
    else if (!pend_q || dir_q != outHi)
    begin
      decPend    = 1'b1; // R4 R14
      decDir     = outHi;
      decPendVal = sample_q;
      decRun     = 12'h001;
    end
    else if (runNext >= cfg_q.tlimit)
    begin
      decFlush = 1'b1; // R12
      decIns   = 1'b1;
    end
    else
    begin
      decIns     = 1'b1; // R6
      decInsVal  = pendVal_q;
      decPend    = 1'b1;
      decPendVal = sample_q;
      decRun     = runNext;
    end
  end

  // Window maintenance
  assign needPop  = winCnt_q >= {1'b0, cfg_q.samples};
  assign insGo    = (state_q == ST_INS) && winPushReady
                    && (!needPop || winValid);
  assign trim     = (state_q == ST_IDLE) && !inTake && winValid
                    && (winCnt_q > {1'b0, cfg_q.samples});
  assign winFlush = (state_q == ST_EVAL) && decFlush;
  assign winPush  = insGo;
  assign winPop   = (insGo && needPop) || trim;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sum_q    <= '0;
      winCnt_q <= '0;
    end
    else if (winFlush)
    begin
      sum_q    <= '0; // R12
      winCnt_q <= '0;
    end
    else if (insGo)
    begin
      sum_q <= sum_q + SUM_W'(insVal_q)
               - (needPop ? SUM_W'(winData) : '0); // R8
      if (!needPop)
        winCnt_q <= winCnt_q + 1'b1;
    end
    else if (trim)
    begin
      sum_q    <= sum_q - SUM_W'(winData); // R10
      winCnt_q <= winCnt_q - 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE: if (inTake) state_q <= ST_EVAL;
        ST_EVAL: state_q <= decIns ? ST_INS : ST_OUT;
        ST_INS:  if (insGo) state_q <= ST_OUT;
        ST_OUT:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Held-sample and timer bookkeeping
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_q  <= '0;
      pend_q    <= 1'b0;
      dir_q     <= 1'b0;
      pendVal_q <= '0;
      run_q     <= '0;
      insVal_q  <= '0;
    end
    else
    begin
      if (inTake)
        sample_q <= inData;
      if (state_q == ST_EVAL)
      begin
        pend_q    <= decPend;
        dir_q     <= decDir;
        pendVal_q <= decPendVal;
        run_q     <= decRun; // R15
        insVal_q  <= decInsVal;
      end
    end
  end

  // Output stream
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avg_q       <= '0;
      flowValid_q <= 1'b0;
      flowData_q  <= '0;
    end
    else
    begin
      flowValid_q <= (state_q == ST_OUT);
      if (state_q == ST_OUT)
      begin
        avg_q      <= quot[DATA_W-1:0]; // R8
        flowData_q <= cfg_q.enable ? quot[DATA_W-1:0] : sample_q; // R13
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic evalOn;
  assign evalOn = (state_q == ST_EVAL) && cfg_q.enable && (winCnt_q != '0);

  upper_bound_a: assert property ( // R1
    evalOn && !pend_q && 32'(sample_q) * 32'(PCT_SCALE)
      > 32'(avg_q) * (32'(PCT_SCALE) + 32'(cfg_q.percent))
    |=> pend_q && dir_q && state_q == ST_OUT)
    else $error("upper outlier not held");
  lower_bound_a: assert property ( // R2
    evalOn && !pend_q && 32'(sample_q) * 32'(PCT_SCALE)
      < 32'(avg_q) * (32'(PCT_SCALE) - 32'(cfg_q.percent))
    |=> pend_q && !dir_q && state_q == ST_OUT)
    else $error("lower outlier not held");
  in_band_a: assert property ( // R3
    evalOn && !outHi && !outLo
    |=> state_q == ST_INS && insVal_q == $past(sample_q) && !pend_q)
    else $error("in-band sample not inserted");
  hold_avg_a: assert property ( // R4
    evalOn && (outHi || outLo) && !pend_q
    |=> $stable(sum_q) ##1 flowValid_q)
    else $error("held sample disturbed the average");
  spike_drop_a: assert property ( // R5
    evalOn && pend_q && !outHi && !outLo
    |=> !pend_q && state_q == ST_INS && insVal_q == $past(sample_q))
    else $error("spike not discarded");
  confirm_add_a: assert property ( // R6
    evalOn && pend_q && dir_q == outHi && (outHi || outLo)
      && runNext < cfg_q.tlimit
    |=> state_q == ST_INS && insVal_q == $past(pendVal_q))
    else $error("confirmed sample not added");
  slot_wait_a: assert property ( // R7
    state_q == ST_IDLE && !tickPend_q |=> state_q == ST_IDLE)
    else $error("sample taken outside a slot");
  avg_out_a: assert property ( // R8
    state_q == ST_OUT && cfg_q.enable && winCnt_q != '0
    |=> flowValid_q
        && flowData_q == 16'($past(sum_q) / SUM_W'($past(winCnt_q))))
    else $error("output is not the running average");
  window_len_a: assert property ( // R10
    state_q == ST_OUT |-> winCnt_q <= {1'b0, cfg_q.samples})
    else $error("window longer than sample count");
  restart_a: assert property ( // R12
    evalOn && pend_q && dir_q == outHi && (outHi || outLo)
      && runNext >= cfg_q.tlimit
    |=> winCnt_q == '0 ##1 winCnt_q == 8'h01
        && sum_q == SUM_W'($past(sample_q, 2)))
    else $error("time limit did not restart average");
  bypass_a: assert property ( // R13
    state_q == ST_OUT && !cfg_q.enable |=> flowData_q == $past(sample_q))
    else $error("disabled filter did not pass sample");
  opposite_a: assert property ( // R14
    evalOn && pend_q && dir_q != outHi && (outHi || outLo)
    |=> pend_q && pendVal_q == $past(sample_q) && run_q == 12'h001)
    else $error("opposite outlier not re-held");

  spike_c:   cover property (evalOn && pend_q && !outHi && !outLo);
  confirm_c: cover property (evalOn && pend_q && dir_q == outHi && outHi);
  restart_c: cover property (winFlush && cfg_q.enable);
endmodule

/* File: sim/fsr_sensor_model.sv */
// Behavioural flow sensor front end offering samples on valid and ready
`timescale 1ns/10ps
module fsr_sensor_model
  import fsr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [3:0]        gapCycles,
  input  wire logic              sampleReady,
  output logic                   sampleValid,
  output logic [DATA_W-1:0]      sampleData
);
  logic [DATA_W-1:0] sendQ[$];
  logic [3:0]        wait_q;

  task automatic push(input logic [DATA_W-1:0] d);
    sendQ.push_back(d);
  endtask

  // Offer held until taken; idle line toggles so no stale word shows
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sampleValid <= 1'b0;
      sampleData  <= '0;
      wait_q      <= 4'h0;
    end
    else if (!sampleValid || sampleReady)
    begin
      if (wait_q != 4'h0 || sendQ.size() == 0)
      begin
        sampleValid <= 1'b0;
        sampleData  <= ~sampleData;
        wait_q      <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
      end
      else
      begin
        sampleValid <= 1'b1;
        sampleData  <= sendQ.pop_front();
        wait_q      <= gapCycles;
      end
    end
  end
endmodule

/* File: sim/tb_flow_spike_rejection_filter.sv */
// Self-checking bench for the flow spike rejection filter
`timescale 1ns/10ps
module tb_flow_spike_rejection_filter;
  import fsr_pkg::*;

  localparam int TICK  = 20;
  localparam int LIMIT = 12000;

  logic              clk;
  logic              resetn;
  fsr_bus_t          bus;
  logic [31:0]       rdData;
  logic              sampleValid;
  logic              sampleReady;
  logic [DATA_W-1:0] sampleData;
  logic              flowValid;
  logic [DATA_W-1:0] flowData;
  logic [3:0]        gapCycles;
  logic              sawFull;
  logic [31:0]       expOut;
  int                miscompares;
  int                checks_done;
  int                seed;
  int                cycles;
  int                lastOut;
  int                win[$];
  int                expQ[$];
  bit                mEn;
  int                mSamples;
  int                mPct;
  int                mTlim;
  bit                pend;
  bit                pDir;
  int                pVal;
  int                timer;
  int                mAvg;
  logic [15:0]       hand[20] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8,
    16'h041a, 16'h04b0, 16'h03f2, 16'h0514, 16'h02bc, 16'h03e8, 16'h0514,
    16'h0514, 16'h1388, 16'h1388, 16'h1388, 16'h1388, 16'h1388, 16'h1388,
    16'h1388, 16'h2328};
  logic [7:0]        ca[5] = '{REG_SAMPLES, REG_SAMPLES, REG_PERCENT,
    REG_TLIMIT, REG_TLIMIT};
  logic [31:0]       cw[5] = '{32'hc8, 32'h0, 32'h96, 32'h1, 32'hfa0};
  logic [31:0]       ce[5] = '{32'h7d, 32'h1, 32'h64, 32'h6, 32'ha00};

  fsr_filter #(.TICK_CYCLES(TICK)) fsr_filter_i (.clk(clk), .resetn(resetn),
    .bus(bus), .rdData(rdData), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData),
    .flowValid(flowValid), .flowData(flowData));

  fsr_sensor_model fsr_sensor_model_i (.clk(clk), .resetn(resetn),
    .gapCycles(gapCycles), .sampleReady(sampleReady),
    .sampleValid(sampleValid), .sampleData(sampleData));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(rdData, e);
  endtask

  function automatic int avgOf();
    int s;
    s = 0;
    foreach (win[i]) s += win[i];
    return (win.size() > 0) ? s / win.size() : 0;
  endfunction

  function automatic void put(input int x);
    win.push_back(x);
    while (win.size() > mSamples) void'(win.pop_front());
  endfunction

  // Expected output of one sample, updating the mirrored filter state
  function automatic int step(input int x);
    int a;
    int d;
    bit dir;
    if (!mEn) return x;
    // Band uses the last output average, not a freshly trimmed window
    a = mAvg;
    d = a * mPct / 100;
    dir = x > a + d;
    if (win.size() == 0 || (x >= a - d && x <= a + d))
    begin
      put(x);
      pend = 0;
      timer = 0;
    end
    else if (!pend || dir != pDir)
    begin
      pend = 1;
      pDir = dir;
      timer = 1;
      pVal = x;
    end
    else
    begin
      timer++;
      if (timer >= mTlim)
      begin
        win.delete();
        put(x);
        pend = 0;
        timer = 0;
      end
      else
        put(pVal);
      pVal = x;
    end
    mAvg = avgOf();
    return mAvg;
  endfunction

  function automatic int rnd();
    int x;
    x = 900 + {$random(seed)} % 200;
    if ({$random(seed)} % 5 == 0) x += 600;
    return x;
  endfunction

  task automatic cfg(input bit en, input int s, input int p, input int t);
    wr(REG_CTRL, 32'(en));
    wr(REG_SAMPLES, 32'(s));
    wr(REG_PERCENT, 32'(p));
    wr(REG_TLIMIT, 32'(t));
    mEn = en;
    mSamples = s;
    mPct = p;
    mTlim = t;
    while (win.size() > s) void'(win.pop_front());
    if (!en) win.delete();
    if (!en) pend = 0;
  endtask

  task automatic send(input int x);
    expQ.push_back(step(x));
    fsr_sensor_model_i.push(16'(x));
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (expQ.size() > 0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    check(32'(expQ.size()), 32'h0);
    lastOut = -1;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (resetn && sampleReady === 1'b0) sawFull <= 1'b1;
    if (cycles == LIMIT)
    begin
      miscompares++;
      summarize();
    end
  end

  always @(posedge clk)
  begin
    if (resetn && flowValid === 1'b1)
    begin
      expOut = (expQ.size() > 0) ? 32'(expQ.pop_front()) : 32'h1_0000;
      check({16'h0000, flowData}, expOut);
      if (lastOut > 0)
        check(32'(cycles - lastOut >= TICK - 2), 32'h1);
      // First take of a batch may fall anywhere in its slot
      lastOut = (lastOut < 0) ? 0 : cycles;
    end
  end

  initial
  begin
    seed = 26;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    lastOut = -1;
    mAvg = 0;
    sawFull = 1'b0;
    resetn = 1'b0;
    bus = '0;
    gapCycles = 4'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rdchk(REG_CTRL, 32'h1);
    rdchk(REG_SAMPLES, 32'h5a);
    rdchk(REG_PERCENT, 32'h2);
    rdchk(REG_TLIMIT, 32'h14);
    rdchk(REG_AVG, 32'h0);
    wr(8'h20, 32'h5);
    rdchk(8'h20, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(ca[i], cw[i]);
      rdchk(ca[i], ce[i]);
    end
    cfg(1'b1, 20, 10, 6);
    foreach (hand[i]) send(hand[i]);
    drain();
    rdchk(REG_AVG, 32'(avgOf()));
    rdchk(REG_STATUS, 32'(win.size() << 8 | pDir << 1 | pend));
    cfg(1'b1, 7, 5, 8);
    for (int i = 0; i < 30; i++) send(rnd());
    drain();
    check(32'(sawFull), 32'h1);
    cfg(1'b0, 7, 5, 8);
    gapCycles <= 4'h3;
    for (int i = 0; i < 8; i++) send({$random(seed)} % 65536);
    drain();
    cfg(1'b1, 1, 0, 6);
    for (int i = 0; i < 12; i++) send(rnd());
    drain();
    rdchk(REG_AVG, 32'(avgOf()));
    summarize();
  end
endmodule
